// ### csr_pkg.sv
// Package of constants and types for the processor status register block
package csr_pkg;
  // ------------------------------------------------------------------
  // Address map
  // ------------------------------------------------------------------
  localparam logic [8:0] CPU_STATUS_BANK0 = 9'h003;
  localparam logic [8:0] CPU_STATUS_BANK1 = 9'h083;
  localparam logic [8:0] CPU_STATUS_BANK2 = 9'h103;
  localparam logic [8:0] CPU_STATUS_BANK3 = 9'h183;
  localparam logic [6:0] CPU_STATUS_LOW7 = 7'h03;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int BIT_CARRY = 0;
  localparam int BIT_DIGIT_CARRY = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_POWERDOWN_N = 3;
  localparam int BIT_TIMEOUT_N = 4;
  localparam int BIT_BANK_LO = 5;
  localparam int BIT_BANK_HI = 6;
  localparam int BIT_INDIRECT_BANK = 7;
  // Software-writable bits outside the arithmetic flags
  localparam logic [7:0] SW_BANK_MASK = 8'hE0;
  localparam logic [7:0] ARITH_MASK = 8'h07;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] BANK_RESET = 3'h0;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic ONE = 1'b1;
  localparam logic ZERO = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ------------------------------------------------------------------
  // ALU operation codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CSR_OP_NONE = 3'h0,
    CSR_OP_ADD = 3'h1,
    CSR_OP_SUB = 3'h2,
    CSR_OP_LOGIC = 3'h3,
    CSR_OP_CLEAR = 3'h4,
    CSR_OP_MOVE = 3'h5
  } csr_op_t;
  // Reset cause events
  typedef enum logic [3:0] {
    CSR_EV_IDLE = 4'h1,
    CSR_EV_WDT_TIMEOUT = 4'h2,
    CSR_EV_SLEEP = 4'h4,
    CSR_EV_CLRWDT = 4'h8
  } csr_ev_t;
endpackage

// ### csr_alu_flags.sv
// Flag generator: zero, digit carry and carry for the executing operation
`timescale 1ns/1ps
module csr_alu_flags (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire csr_pkg::csr_op_t op,
  input wire logic [7:0] logic_result,
  output logic [7:0] result,
  output logic zero,
  output logic digit_carry,
  output logic carry,
  output logic dc_c_valid
);
  logic [4:0] nib;
  logic [8:0] full;
  always_comb begin
    nib = 5'h00;
    full = 9'h000;
    result = logic_result;
    dc_c_valid = 1'b0;
    unique case (op)
      csr_pkg::CSR_OP_ADD: begin
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        full = {1'b0, a} + {1'b0, b};
        dc_c_valid = 1'b1;
      end
      csr_pkg::CSR_OP_SUB: begin
        // a - b as a + ~b + 1: carry-outs are inverted borrows
        nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        dc_c_valid = 1'b1;
      end
      csr_pkg::CSR_OP_CLEAR: begin
        result = csr_pkg::READ_ZERO;
      end
      default: begin
      end
    endcase
    if (dc_c_valid) begin
      result = full[7:0];
    end
    zero = (result == csr_pkg::READ_ZERO);
    digit_carry = nib[4];
    carry = full[8];
  end
endmodule

// ### csr_status.sv
// Processor status register: flags, reset cause bits and bank selects
`timescale 1ns/1ps
// Overview of operation
// - The status register answers at 03h, 83h, 103h and 183h, in every bank.
// - Any instruction may name the status register as its destination.
// - Flag-affecting ops aimed at the status register do not write Z, DC, C by data.
// - Software writes never change the time-out and power-down bits.
// - Clear-file on the status register zeroes bank bits, sets Z, keeps the rest.
// - In subtraction carry is an inverted borrow and digit carry an inverted digit borrow.
// - Unimplemented locations of this map read as zero.
module csr_status (
  clk,
  resetn,
  op,
  op_a,
  op_b,
  logic_result,
  flags_affected,
  dest_file,
  wr_en,
  addr_low7,
  fsr,
  ev,
  rd_en,
  rd_addr,
  rd_data,
  result,
  status_q_out,
  direct_addr,
  indirect_addr,
  indirect_bank_select,
  direct_bank_select_hi,
  direct_bank_select_lo,
  timeout_flag_n,
  powerdown_flag_n,
  zero_flag,
  digit_carry_flag,
  carry_flag
);
  input wire logic clk;
  input wire logic resetn;
  input wire csr_pkg::csr_op_t op;
  input wire logic [7:0] op_a;
  input wire logic [7:0] op_b;
  input wire logic [7:0] logic_result;
  input wire logic flags_affected;
  input wire logic dest_file;
  input wire logic wr_en;
  input wire logic [6:0] addr_low7;
  input wire logic [7:0] fsr;
  input wire csr_pkg::csr_ev_t ev;
  input wire logic rd_en;
  input wire logic [8:0] rd_addr;
  output logic [7:0] rd_data;
  output logic [7:0] result;
  output logic [7:0] status_q_out;
  output logic [8:0] direct_addr;
  output logic [8:0] indirect_addr;
  output logic indirect_bank_select;
  output logic direct_bank_select_hi;
  output logic direct_bank_select_lo;
  output logic timeout_flag_n;
  output logic powerdown_flag_n;
  output logic zero_flag;
  output logic digit_carry_flag;
  output logic carry_flag;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] rd_data;
  } csr_state_t;

  csr_state_t s_q;
  csr_state_t s_d;

  logic alu_z;
  logic alu_dc;
  logic alu_c;
  logic alu_dcc_valid;
  logic [7:0] alu_res;
  logic [8:0] wr_full_addr;
  logic hit_wr;

  function automatic logic is_status_addr(input logic [8:0] adr);
    is_status_addr = (adr == csr_pkg::CPU_STATUS_BANK0) ||
      (adr == csr_pkg::CPU_STATUS_BANK1) ||
      (adr == csr_pkg::CPU_STATUS_BANK2) ||
      (adr == csr_pkg::CPU_STATUS_BANK3);
  endfunction

  csr_alu_flags u_flags (
    .a(op_a),
    .b(op_b),
    .op(op),
    .logic_result(logic_result),
    .result(alu_res),
    .zero(alu_z),
    .digit_carry(alu_dc),
    .carry(alu_c),
    .dc_c_valid(alu_dcc_valid)
  );

  // ------------------------------------------------------------------
  // Bank addressing
  // ------------------------------------------------------------------
  assign direct_addr = {s_q.status[csr_pkg::BIT_BANK_HI],
    s_q.status[csr_pkg::BIT_BANK_LO], addr_low7};
  assign indirect_addr = {s_q.status[csr_pkg::BIT_INDIRECT_BANK], fsr};
  assign wr_full_addr = direct_addr;
  assign hit_wr = wr_en && dest_file && is_status_addr(wr_full_addr);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Data write first, then flag logic overrides the arithmetic bits
    if (hit_wr) begin
      if (flags_affected) begin
        // Only bank bits take data; Z, and DC/C on add/sub only, come from flag logic
        s_d.status = (s_q.status & ~csr_pkg::SW_BANK_MASK) |
          (alu_res & csr_pkg::SW_BANK_MASK);
      end else begin
        s_d.status = (s_q.status & ~(csr_pkg::SW_BANK_MASK | csr_pkg::ARITH_MASK)) |
          (alu_res & (csr_pkg::SW_BANK_MASK | csr_pkg::ARITH_MASK));
      end
    end
    if (wr_en && flags_affected) begin
      s_d.status[csr_pkg::BIT_ZERO] = alu_z;
      if (alu_dcc_valid) begin
        s_d.status[csr_pkg::BIT_DIGIT_CARRY] = alu_dc;
        s_d.status[csr_pkg::BIT_CARRY] = alu_c;
      end
    end
    // Reset cause bits: only hardware events move them
    unique case (ev)
      csr_pkg::CSR_EV_WDT_TIMEOUT: begin
        s_d.status[csr_pkg::BIT_TIMEOUT_N] = csr_pkg::ZERO;
      end
      csr_pkg::CSR_EV_SLEEP: begin
        s_d.status[csr_pkg::BIT_TIMEOUT_N] = csr_pkg::ONE;
        s_d.status[csr_pkg::BIT_POWERDOWN_N] = csr_pkg::ZERO;
      end
      csr_pkg::CSR_EV_CLRWDT: begin
        s_d.status[csr_pkg::BIT_TIMEOUT_N] = csr_pkg::ONE;
        s_d.status[csr_pkg::BIT_POWERDOWN_N] = csr_pkg::ONE;
      end
      default: begin
      end
    endcase
    // Read port: one-cycle latency, zero for anything but this register
    s_d.rd_data = csr_pkg::READ_ZERO;
    if (rd_en && is_status_addr(rd_addr)) begin
      s_d.rd_data = s_q.status;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // Power-up value: banks 0, reset cause bits high, flags cleared
      s_q.status <= csr_pkg::STATUS_RESET;
      s_q.rd_data <= csr_pkg::READ_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd_data;
  assign result = alu_res;
  assign status_q_out = s_q.status;
  assign indirect_bank_select = s_q.status[csr_pkg::BIT_INDIRECT_BANK];
  assign direct_bank_select_hi = s_q.status[csr_pkg::BIT_BANK_HI];
  assign direct_bank_select_lo = s_q.status[csr_pkg::BIT_BANK_LO];
  assign timeout_flag_n = s_q.status[csr_pkg::BIT_TIMEOUT_N];
  assign powerdown_flag_n = s_q.status[csr_pkg::BIT_POWERDOWN_N];
  assign zero_flag = s_q.status[csr_pkg::BIT_ZERO];
  assign digit_carry_flag = s_q.status[csr_pkg::BIT_DIGIT_CARRY];
  assign carry_flag = s_q.status[csr_pkg::BIT_CARRY];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_mirror;
    @(posedge clk) disable iff (!resetn)
      rd_en && is_status_addr(rd_addr) && !hit_wr && ev == csr_pkg::CSR_EV_IDLE
      |=> rd_data == $past(s_q.status);
  endproperty
  a_mirror: assert property (p_mirror) else $error("status read mismatch");

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
      !(rd_en && is_status_addr(rd_addr)) |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_to_pd_sw;
    @(posedge clk) disable iff (!resetn)
      ev == csr_pkg::CSR_EV_IDLE |=> $stable(s_q.status[4:3]);
  endproperty
  a_to_pd_sw: assert property (p_to_pd_sw) else $error("reset cause bits changed");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      hit_wr && flags_affected && op == csr_pkg::CSR_OP_CLEAR
      ##0 ev == csr_pkg::CSR_EV_IDLE
      |=> s_q.status[7:5] == 3'h0 && s_q.status[2] &&
        s_q.status[4:3] == $past(s_q.status[4:3]) &&
        s_q.status[1:0] == $past(s_q.status[1:0]);
  endproperty
  a_clear: assert property (p_clear) else $error("clear-file result wrong");

  property p_data_write;
    @(posedge clk) disable iff (!resetn)
      hit_wr && !flags_affected |=> s_q.status[7:5] == $past(alu_res[7:5]) &&
        s_q.status[2:0] == $past(alu_res[2:0]);
  endproperty
  a_data_write: assert property (p_data_write) else $error("plain write lost");

  property p_flag_block;
    @(posedge clk) disable iff (!resetn)
      hit_wr && flags_affected && alu_dcc_valid |=>
        s_q.status[1:0] == $past({alu_dc, alu_c});
  endproperty
  a_flag_block: assert property (p_flag_block) else $error("data wrote arith flags");

  property p_sub_borrow;
    @(posedge clk) disable iff (!resetn)
      wr_en && flags_affected && op == csr_pkg::CSR_OP_SUB |=>
        s_q.status[0] == ($past(op_a) >= $past(op_b));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow sense wrong");

  // Whatever bank is selected, low address 03h must reach this register
  property p_bank;
    @(posedge clk) disable iff (!resetn)
      (wr_en && dest_file && addr_low7 == csr_pkg::CPU_STATUS_LOW7) == hit_wr;
  endproperty
  a_bank: assert property (p_bank) else $error("bank mirror decode wrong");

  property p_zero;
    @(posedge clk) disable iff (!resetn)
      wr_en && flags_affected |=> s_q.status[2] == ($past(alu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  c_clear: cover property (@(posedge clk) hit_wr && op == csr_pkg::CSR_OP_CLEAR);
  c_sub: cover property (@(posedge clk) wr_en && flags_affected && op == csr_pkg::CSR_OP_SUB);
  c_sleep: cover property (@(posedge clk) ev == csr_pkg::CSR_EV_SLEEP);
  c_bank3: cover property (@(posedge clk) s_q.status[6:5] == 2'h3);
endmodule

// ### csr_cpu_model.sv
// Instruction execution model driving the status register block
`timescale 1ns/1ps
module csr_cpu_model (
  clk,
  op,
  op_a,
  op_b,
  logic_result,
  flags_affected,
  wr_en,
  addr_low7
);
  input wire logic clk;
  output csr_pkg::csr_op_t op;
  output logic [7:0] op_a;
  output logic [7:0] op_b;
  output logic [7:0] logic_result;
  output logic flags_affected;
  output logic wr_en;
  output logic [6:0] addr_low7;
  initial begin
    op = csr_pkg::CSR_OP_NONE;
    {op_a, op_b, logic_result, flags_affected, wr_en, addr_low7} = '0;
  end
  // Software moves use MOVE without flags so Z, DC and C take the moved data
  task automatic exec(input csr_pkg::csr_op_t o, input logic [7:0] a, input logic [7:0] b,
                      input logic fa, input logic [6:0] ad);
    @(posedge clk);
    op <= o;
    op_a <= a;
    op_b <= b;
    logic_result <= a;
    flags_affected <= fa;
    addr_low7 <= ad;
    wr_en <= 1'b1;
    @(posedge clk);
    // Operands held so the combinational result stays checkable
    wr_en <= 1'b0;
  endtask
endmodule

// ### test_csr_status.sv
// Self-checking testbench of the processor status register
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module test_csr_status;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rd_en = 1'b0;
  logic [8:0] rd_addr = 9'h000;
  logic [7:0] fsr = 8'h00;
  csr_pkg::csr_ev_t ev = csr_pkg::CSR_EV_IDLE;
  csr_pkg::csr_op_t op;
  logic [7:0] op_a, op_b, logic_result, rd_data, st, sb, e, res;
  logic dest_file = 1'b1;
  logic flags_affected, wr_en;
  logic [6:0] addr_low7;
  logic [8:0] direct_addr, indirect_addr;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [21:0] T [6] = '{{3'h1, 8'h0F, 8'h01, 3'h2}, {3'h1, 8'h80, 8'h80, 3'h5},
    {3'h2, 8'h05, 8'h03, 3'h3}, {3'h2, 8'h10, 8'h01, 3'h1},
    {3'h2, 8'h05, 8'h05, 3'h7}, {3'h2, 8'h03, 8'h05, 3'h0}};
  always #12.5 clk = ~clk;
  csr_cpu_model cpu (.clk, .op, .op_a, .op_b, .logic_result, .flags_affected, .wr_en,
    .addr_low7);
  csr_status dut (.clk, .resetn, .op, .op_a, .op_b, .logic_result, .flags_affected,
    .dest_file, .wr_en, .addr_low7, .fsr, .ev, .rd_en, .rd_addr, .rd_data,
    .result(res), .status_q_out(st), .direct_addr, .indirect_addr,
    .indirect_bank_select(sb[7]), .direct_bank_select_hi(sb[6]),
    .direct_bank_select_lo(sb[5]), .timeout_flag_n(sb[4]), .powerdown_flag_n(sb[3]),
    .zero_flag(sb[2]), .digit_carry_flag(sb[1]), .carry_flag(sb[0]));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic ex(input logic [2:0] o, input logic [7:0] a, input logic [7:0] b,
                    input logic fa, input logic [6:0] ad);
    logic [7:0] r;
    r = (o == 3'h1) ? a + b : (o == 3'h2) ? a - b : (o == 3'h4) ? 8'h00 : a;
    cpu.exec(csr_pkg::csr_op_t'(o), a, b, fa, ad);
    #1;
    `CHK(sb, st)
    `CHK(st, e)
    `CHK(res, r)
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] x);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    `CHK(rd_data, x)
  endtask
  task automatic event_in(input csr_pkg::csr_ev_t v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= csr_pkg::CSR_EV_IDLE;
    #1;
    `CHK(st, e)
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_map;
    e = 8'h18;
    `CHK(st, e)
    rd(9'h003, e);
    rd(9'h083, e);
    rd(9'h103, e);
    rd(9'h183, e);
    rd(9'h004, 8'h00);
    rd(9'h1A0, 8'h00);
  endtask
  task automatic t_write;
    @(posedge clk);
    fsr <= 8'h5A;
    e = 8'hBD;
    ex(3'h5, 8'hA5, 8'h00, 1'b0, 7'h03);
    `CHK(direct_addr, {2'b01, addr_low7})
    `CHK(indirect_addr, 9'h15A)
    e = 8'h58;
    ex(3'h5, 8'h40, 8'h00, 1'b0, 7'h03);
    `CHK(direct_addr, {2'b10, addr_low7})
    `CHK(indirect_addr, 9'h05A)
    ex(3'h5, 8'h00, 8'h00, 1'b0, 7'h04);
    // Result bound for the working register must leave the status alone
    @(posedge clk);
    dest_file <= 1'b0;
    ex(3'h5, 8'h00, 8'h00, 1'b0, 7'h03);
    @(posedge clk);
    dest_file <= 1'b1;
  endtask
  task automatic t_events;
    e = 8'h50;
    event_in(csr_pkg::CSR_EV_SLEEP);
    e = 8'h40;
    event_in(csr_pkg::CSR_EV_WDT_TIMEOUT);
    e = 8'h00;
    ex(3'h5, 8'h18, 8'h00, 1'b0, 7'h03);
    e = 8'h18;
    event_in(csr_pkg::CSR_EV_CLRWDT);
  endtask
  task automatic t_clear;
    e = 8'hFB;
    ex(3'h5, 8'hE3, 8'h00, 1'b0, 7'h03);
    e = 8'h1F;
    ex(3'h4, 8'hAA, 8'h00, 1'b1, 7'h03);
  endtask
  task automatic t_arith;
    for (int i = 0; i < 6; i++) begin
      e = {5'h03, T[i][2:0]};
      ex(T[i][21:19], T[i][18:11], T[i][10:3], 1'b1, 7'h20);
    end
    e = 8'h1F;
    ex(3'h1, 8'hFF, 8'h01, 1'b1, 7'h03);
    e = 8'h1B;
    ex(3'h3, 8'h01, 8'h00, 1'b1, 7'h20);
  endtask
  task automatic t_reset;
    e = 8'h0B;
    event_in(csr_pkg::CSR_EV_WDT_TIMEOUT);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    e = 8'h18;
    #1;
    `CHK(st, e)
    `CHK(rd_data, 8'h00)
    rd(9'h083, e);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_map();
    t_write();
    t_events();
    t_clear();
    t_arith();
    t_reset();
    complete_run();
  end
endmodule
